// ### include/pwmos_pkg.sv
// pwm output stage: constants, register map, state, bus and register types
// assumes a 40 MHz mclk and an AXI4-Lite master with 32-bit data
package pwmos_pkg;

    localparam int ADDR_W = 16;

    localparam logic [15:0] IDX_SWTRIP = 16'h2061;
    localparam logic [15:0] IDX_STEER = 16'h2062;
    localparam logic [15:0] IDX_CHOP = 16'h2063;
    localparam logic [15:0] IDX_STATUS = 16'h2064;
    localparam logic [15:0] ADDR_SWTRIP = {IDX_SWTRIP[13:0], 2'b00};
    localparam logic [15:0] ADDR_STEER = {IDX_STEER[13:0], 2'b00};
    localparam logic [15:0] ADDR_CHOP = {IDX_CHOP[13:0], 2'b00};
    localparam logic [15:0] ADDR_STATUS = {IDX_STATUS[13:0], 2'b00};

    localparam int STEER_W = 9;
    localparam int STEER_XO_LSB = 6;
    localparam int CHOP_W = 10;
    localparam int CHOP_DIV_W = 8;
    localparam int CHOP_HI_BIT = 8;
    localparam int CHOP_LO_BIT = 9;
    localparam int STAT_PIN_BIT = 0;
    localparam int STAT_TRIP_BIT = 1;
    localparam int STAT_RUN_BIT = 2;
    localparam int TU_WRITES = 4;
    localparam logic [8:0] STEER_RST = 9'h000;
    localparam logic [9:0] CHOP_RST = 10'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_RUN = 3'b010,
        ST_TRIP = 3'b100
    } pwmos_state_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } pwmos_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pwmos_axi_rsp_t;

    typedef struct packed {
        logic [8:0] steerShadow;
        logic [8:0] steerAct;
        logic [9:0] chopCtrl;
        logic swFlag;
        pwmos_state_t mode;
        logic [3:0] wrMask;
        logic [2:0] pinSync;
        logic [2:0] lineSync;
        logic pinLvl;
        logic lineLvl;
        logic syncPrev;
        logic halfPrev;
        logic [8:0] chopCnt;
        logic carrier;
        logic [5:0] outReg;
        logic irq;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } pwmos_regs_t;

    localparam pwmos_regs_t REGS_RST = '{
        steerShadow: STEER_RST, steerAct: STEER_RST, chopCtrl: CHOP_RST,
        mode: ST_WAIT, pinSync: 3'h7, lineSync: 3'h7, pinLvl: 1'b1,
        lineLvl: 1'b1, default: '0};

endpackage

// ### design/pwmos_output_stage.sv
// pwm output stage: crossover, disable, chopping, trip shutdown
// assumes the timing unit and its register writes share mclk
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pwmos_output_stage
    import pwmos_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire pwmos_axi_req_t axiReq,
    output pwmos_axi_rsp_t axiRsp,
    input wire logic [5:0] tuOut,
    input wire logic cycleSyncIn,
    input wire logic halfCycle,
    input wire logic doubleUpdate,
    input wire logic [3:0] tuWrite,
    input wire logic faultInput_n,
    input wire logic [2:0] senseOutOfRange,
    input wire logic [2:0] senseFloating,
    output logic [5:0] pwmOut,
    output logic cycleSyncPulse,
    output logic faultIrq
);

    // ---------------------------------------------
    // state and async fault line
    // ---------------------------------------------
    pwmos_regs_t r;
    pwmos_regs_t s;
    logic lineRaw;
    logic [5:0] shaped;
    logic wrGo;
    logic rdGo;
    logic swWrite;
    logic rdSwt;
    logic lineFall;
    logic tripEvent;
    logic syncRise;
    logic midRise;
    logic [8:0] chopTop;

    assign lineRaw = faultInput_n & ~|{senseOutOfRange, senseFloating};
    assign pwmOut = r.outReg & {6{lineRaw}};
    assign cycleSyncPulse = cycleSyncIn & lineRaw & (r.mode == ST_RUN);
    assign faultIrq = r.irq;

    // ---------------------------------------------
    // per-pair routing, gating, chopping
    // ---------------------------------------------
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_pair
            logic xo;
            assign xo = r.steerAct[STEER_XO_LSB + p];
            // route then gate then chop
            assign shaped[2*p] = (xo ? tuOut[2*p+1] : tuOut[2*p])
                & ~r.steerAct[2*p]
                & (~r.chopCtrl[CHOP_HI_BIT] | r.carrier);
            assign shaped[2*p+1] = (xo ? tuOut[2*p] : tuOut[2*p+1])
                & ~r.steerAct[2*p+1]
                & (~r.chopCtrl[CHOP_LO_BIT] | r.carrier);
        end
    endgenerate

    // ---------------------------------------------
    // bus handshakes
    // ---------------------------------------------
    assign wrGo = axiReq.awvalid & axiReq.wvalid & ~r.bvalid;
    assign rdGo = axiReq.arvalid & ~r.rvalid;
    assign swWrite = wrGo & (axiReq.awaddr == ADDR_SWTRIP) & axiReq.wstrb[0];
    assign rdSwt = rdGo & (axiReq.araddr == ADDR_SWTRIP);
    assign lineFall = r.lineLvl & (r.lineSync[1] == r.lineSync[2])
        & ~r.lineSync[2];
    assign tripEvent = lineFall | swWrite;
    assign syncRise = cycleSyncIn & ~r.syncPrev;
    assign midRise = halfCycle & ~r.halfPrev;
    assign chopTop = {r.chopCtrl[CHOP_DIV_W-1:0], 1'b1};

    always_comb begin
        axiRsp.awready = wrGo;
        axiRsp.wready = wrGo;
        axiRsp.bvalid = r.bvalid;
        axiRsp.bresp = r.bresp;
        axiRsp.arready = ~r.rvalid;
        axiRsp.rvalid = r.rvalid;
        axiRsp.rdata = r.rdata;
        axiRsp.rresp = r.rresp;
    end

    function automatic logic [31:0] laneMerge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                m[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return m;
    endfunction

    // ---------------------------------------------
    // next state
    // ---------------------------------------------
    always_comb begin
        logic [31:0] mrg;
        mrg = '0;
        s = r;
        s.irq = 1'b0;
        s.syncPrev = cycleSyncIn;
        s.halfPrev = halfCycle;
        // three-stage synchronisers, change on agreement
        s.pinSync = {r.pinSync[1:0], faultInput_n};
        s.lineSync = {r.lineSync[1:0], lineRaw};
        if (r.pinSync[1] == r.pinSync[2]) begin
            s.pinLvl = r.pinSync[2];
        end
        if (r.lineSync[1] == r.lineSync[2]) begin
            s.lineLvl = r.lineSync[2];
        end
        // steering takes effect at cycle boundaries
        if (syncRise || (doubleUpdate && midRise)) begin
            s.steerAct = r.steerShadow;
        end
        // chopping carrier, period 4*(div+1) clocks
        if (r.chopCnt >= chopTop) begin
            s.chopCnt = '0;
            s.carrier = ~r.carrier;
        end else begin
            s.chopCnt = r.chopCnt + 9'h001;
        end
        // write channel
        if (r.bvalid && axiReq.bready) begin
            s.bvalid = 1'b0;
        end
        if (wrGo) begin
            s.bvalid = 1'b1;
            s.bresp = RESP_OKAY;
            case (axiReq.awaddr)
                ADDR_STEER: begin
                    mrg = laneMerge({23'h0, r.steerShadow}, axiReq.wdata,
                        axiReq.wstrb);
                    s.steerShadow = mrg[8:0];
                end
                ADDR_CHOP: begin
                    mrg = laneMerge({22'h0, r.chopCtrl}, axiReq.wdata,
                        axiReq.wstrb);
                    s.chopCtrl = mrg[9:0];
                end
                ADDR_SWTRIP, ADDR_STATUS: begin
                    s.bresp = RESP_OKAY;
                end
                default: begin
                    s.bresp = RESP_SLVERR;
                end
            endcase
        end
        // read channel
        if (r.rvalid && axiReq.rready) begin
            s.rvalid = 1'b0;
        end
        if (rdGo) begin
            s.rvalid = 1'b1;
            s.rresp = RESP_OKAY;
            case (axiReq.araddr)
                ADDR_SWTRIP: s.rdata = {31'h0, r.swFlag};
                ADDR_STEER: s.rdata = {23'h0, r.steerShadow};
                ADDR_CHOP: s.rdata = {22'h0, r.chopCtrl};
                ADDR_STATUS: begin
                    s.rdata = '0;
                    s.rdata[STAT_PIN_BIT] = r.pinLvl;
                    s.rdata[STAT_TRIP_BIT] = (r.mode == ST_TRIP);
                    s.rdata[STAT_RUN_BIT] = (r.mode == ST_RUN);
                end
                default: begin
                    s.rdata = '0;
                    s.rresp = RESP_SLVERR;
                end
            endcase
        end
        // software trip flag, set beats read-clear
        if (rdSwt) begin
            s.swFlag = 1'b0;
        end
        if (swWrite) begin
            s.swFlag = 1'b1;
        end
        // run control
        case (r.mode)
            ST_RUN: begin
                if (tripEvent) begin
                    s.mode = ST_TRIP;
                    s.wrMask = '0;
                    s.irq = 1'b1;
                end
            end
            ST_WAIT, ST_TRIP: begin
                if (tripEvent) begin
                    s.mode = ST_TRIP;
                    s.wrMask = '0;
                    s.irq = 1'b1;
                end else if (r.lineLvl) begin
                    s.wrMask = r.wrMask | tuWrite;
                    if (r.wrMask == {TU_WRITES{1'b1}}) begin
                        s.mode = ST_RUN;
                    end
                end
            end
            default: begin
                s.mode = ST_WAIT;
            end
        endcase
        // registered outputs, one clock behind the timing unit
        s.outReg = (r.mode == ST_RUN) ? shaped : 6'h00;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r <= REGS_RST;
        end else begin
            r <= s;
        end
    end

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_xover_a;
        (r.mode == ST_RUN && r.steerAct[8] && !r.steerAct[4]
            && !r.chopCtrl[CHOP_HI_BIT]) |=> (r.outReg[4] == $past(tuOut[5]));
    endproperty
    a_xover_a: assert property (p_xover_a)
        else $error("crossover A high does not carry timing low");

    property p_no_xover_c;
        (r.mode == ST_RUN && !r.steerAct[6] && !r.steerAct[1]
            && !r.chopCtrl[CHOP_LO_BIT]) |=> (r.outReg[1] == $past(tuOut[1]));
    endproperty
    a_no_xover_c: assert property (p_no_xover_c)
        else $error("phase C low not passed straight");

    property p_disable;
        r.steerAct[0] && r.steerAct[1] |=> (r.outReg[1:0] == 2'b00);
    endproperty
    a_disable: assert property (p_disable)
        else $error("disabled leg still switching");

    property p_steer_hold;
        !syncRise && !(doubleUpdate && midRise) |=> $stable(r.steerAct);
    endproperty
    a_steer_hold: assert property (p_steer_hold)
        else $error("steering changed outside a cycle boundary");

    property p_steer_take;
        syncRise |=> (r.steerAct == $past(r.steerShadow));
    endproperty
    a_steer_take: assert property (p_steer_take)
        else $error("steering not latched on sync rise");

    property p_async_off;
        !lineRaw |-> (pwmOut == 6'h00 && !cycleSyncPulse);
    endproperty
    a_async_off: assert property (p_async_off)
        else $error("outputs active while fault line low");

    property p_trip_off;
        tripEvent |=> faultIrq ##0 (r.mode == ST_TRIP) ##1 (r.outReg == 6'h00);
    endproperty
    a_trip_off: assert property (p_trip_off)
        else $error("trip did not shut down outputs");

    property p_sw_flag;
        swWrite |=> r.swFlag;
    endproperty
    a_sw_flag: assert property (p_sw_flag)
        else $error("software trip flag not set");

    property p_rd_clear;
        rdSwt && !swWrite |=> !r.swFlag ##0 (axiRsp.rdata[0] == $past(r.swFlag));
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("trip read did not report and clear");

    property p_hold_trip;
        (r.mode == ST_TRIP && r.wrMask != 4'hf) |=> (r.mode != ST_RUN);
    endproperty
    a_hold_trip: assert property (p_hold_trip)
        else $error("left shutdown before restart writes");

    property p_resume;
        (r.mode != ST_RUN && r.wrMask == 4'hf && r.lineLvl && !tripEvent)
            |=> (r.mode == ST_RUN);
    endproperty
    a_resume: assert property (p_resume)
        else $error("did not resume after restart writes");

    property p_chop_wrap;
        (r.chopCnt == chopTop) |=> (r.chopCnt == 9'h000)
            ##0 (r.carrier != $past(r.carrier));
    endproperty
    a_chop_wrap: assert property (p_chop_wrap)
        else $error("chop carrier did not toggle at wrap");

    property p_status_pin;
        $changed(r.pinLvl) |-> ($past(r.pinSync[1]) == $past(r.pinSync[2]));
    endproperty
    a_status_pin: assert property (p_status_pin)
        else $error("pin level changed without agreement");

    property p_chop_hi;
        (r.mode == ST_RUN && r.chopCtrl[CHOP_HI_BIT] && !r.carrier)
            |=> (r.outReg[0] == 1'b0 && r.outReg[2] == 1'b0
            && r.outReg[4] == 1'b0);
    endproperty
    a_chop_hi: assert property (p_chop_hi)
        else $error("high side on while carrier low");

    property p_chop_lo;
        (r.mode == ST_RUN && r.chopCtrl[CHOP_LO_BIT] && !r.carrier)
            |=> (r.outReg[1] == 1'b0 && r.outReg[3] == 1'b0
            && r.outReg[5] == 1'b0);
    endproperty
    a_chop_lo: assert property (p_chop_lo)
        else $error("low side on while carrier low");

    property p_dis_all;
        (r.steerAct[5:0] != 6'h00)
            |=> ((r.outReg & $past(r.steerAct[5:0])) == 6'h00);
    endproperty
    a_dis_all: assert property (p_dis_all)
        else $error("disabled output still switching");

    property p_idle_off;
        (r.mode != ST_RUN) |=> (r.outReg == 6'h00);
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("outputs active while not running");

    c_trip: cover property (r.mode == ST_RUN ##1 r.mode == ST_TRIP);
    c_resume: cover property (r.mode == ST_TRIP ##[1:200] r.mode == ST_RUN);
    c_xover: cover property (r.mode == ST_RUN && r.steerAct[7]);
    c_swread: cover property (swWrite ##[1:20] rdSwt);
    c_chop: cover property (r.mode == ST_RUN && r.chopCtrl[CHOP_HI_BIT]);

endmodule // pwmos_output_stage

`default_nettype wire

// ### verif/pwmos_fault_model.sv
// far side: fault pin with pull-down and three current-sense channels
// assumes the bench drives the commands just after a clock edge
`timescale 1ns/1ps
`default_nettype none

module pwmos_fault_model
    import pwmos_pkg::*;
(
    input wire logic pinOpen,
    input wire logic [2:0] overCmd,
    input wire logic [2:0] floatCmd,
    output logic faultInput_n,
    output logic [2:0] senseOutOfRange,
    output logic [2:0] senseFloating
);
    // open pin falls to the pull-down level
    assign faultInput_n = ~pinOpen;
    assign senseOutOfRange = overCmd;
    assign senseFloating = floatCmd;
endmodule // pwmos_fault_model

`default_nettype wire

// ### verif/tb_pwm_output_steer_chop_trip.sv
// bench for the pwm output stage: registers, steering, chop, shutdown
// assumes pwmos_pkg and a 40 MHz mclk
`timescale 1ns/1ps
`default_nettype none

module tb_pwm_output_steer_chop_trip
    import pwmos_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    pwmos_axi_req_t q = '0;
    pwmos_axi_rsp_t r;
    logic [5:0] tuOut = '0;
    logic syncIn = 1'b0;
    logic halfCyc = 1'b0;
    logic dblUpd = 1'b0;
    logic [3:0] tuWr = '0;
    logic pinOpen = 1'b0;
    logic [2:0] overCmd = '0;
    logic [2:0] floatCmd = '0;
    logic faultN;
    logic [2:0] senseOor;
    logic [2:0] senseFlt;
    logic [5:0] pwmOut;
    logic syncOut;
    logic irq;
    int n_errors = 0;
    int checks = 0;
    int irqCnt = 0;
    logic [31:0] seed = 32'h67a7;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [8:0] cur = '0;
    logic [8:0] corner [4] = '{9'h0a7, 9'h003, 9'h1c0, 9'h1ff};

    pwmos_output_stage dut_u (.mclk(mclk), .arst_n(arst_n), .axiReq(q),
        .axiRsp(r), .tuOut(tuOut), .cycleSyncIn(syncIn),
        .halfCycle(halfCyc), .doubleUpdate(dblUpd), .tuWrite(tuWr),
        .faultInput_n(faultN), .senseOutOfRange(senseOor),
        .senseFloating(senseFlt), .pwmOut(pwmOut),
        .cycleSyncPulse(syncOut), .faultIrq(irq));
    pwmos_fault_model far_u (.pinOpen(pinOpen), .overCmd(overCmd),
        .floatCmd(floatCmd), .faultInput_n(faultN),
        .senseOutOfRange(senseOor), .senseFloating(senseFlt));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial forever #12.5 mclk = ~mclk;

    always @(posedge mclk) if (irq === 1'b1) irqCnt++;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [5:0] expOut(input logic [5:0] t,
                                          input logic [8:0] s);
        logic [5:0] x;
        x = t;
        for (int p = 0; p < 3; p++) if (s[6+p]) begin
            x[2*p] = t[2*p+1];
            x[2*p+1] = t[2*p];
        end
        return x & ~s[5:0];
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tdone(input string n);
        $display("test %s done", n);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic axw(input logic [15:0] a, input logic [31:0] d);
        q.awvalid <= 1'b1;
        q.wvalid <= 1'b1;
        q.awaddr <= a;
        q.wdata <= d;
        q.wstrb <= 4'hf;
        q.bready <= 1'b1;
        do @(posedge mclk); while (!(r.awready === 1'b1 && r.wready === 1'b1));
        q.awvalid <= 1'b0;
        q.wvalid <= 1'b0;
        while (r.bvalid !== 1'b1) @(posedge mclk);
        rsp = r.bresp;
        q.bready <= 1'b0;
        tick(1);
    endtask

    task automatic axr(input logic [15:0] a);
        q.arvalid <= 1'b1;
        q.araddr <= a;
        q.rready <= 1'b1;
        do @(posedge mclk); while (r.arready !== 1'b1);
        q.arvalid <= 1'b0;
        while (r.rvalid !== 1'b1) @(posedge mclk);
        rd = r.rdata;
        rsp = r.rresp;
        q.rready <= 1'b0;
        tick(1);
    endtask

    task automatic start();
        for (int i = 0; i < TU_WRITES; i++) begin
            chk("idleOut", 6'h00, pwmOut);
            tuWr <= 4'h1 << i;
            tick(1);
            tuWr <= 4'h0;
            tick(1);
        end
        tick(4);
    endtask

    task automatic sync(input logic ev);
        syncIn <= 1'b1;
        tick(1);
        chk("syncOut", ev, syncOut);
        syncIn <= 1'b0;
        tick(3);
    endtask

    task automatic half();
        halfCyc <= 1'b1;
        tick(1);
        halfCyc <= 1'b0;
        tick(3);
    endtask

    task automatic steer(input logic [8:0] s, input logic [5:0] t,
                         input logic viaHalf);
        tuOut <= t;
        axw(ADDR_STEER, {23'h0, s});
        tick(3);
        chk("heldOut", expOut(t, cur), pwmOut);
        axr(ADDR_STEER);
        chk("steerRd", s, rd);
        if (viaHalf) half();
        else sync(1'b1);
        chk("steerOut", expOut(t, s), pwmOut);
        cur = s;
    endtask

    task automatic chop(input logic [9:0] c, input int hiN, input int loN);
        int h = 0;
        int l = 0;
        axw(ADDR_CHOP, {22'h0, c});
        axr(ADDR_CHOP);
        chk("chopRd", c, rd);
        tick(4);
        repeat (64) begin
            @(posedge mclk);
            h += pwmOut[4];
            l += pwmOut[5];
        end
        chk("chopHi", hiN, h);
        chk("chopLo", loN, l);
    endtask

    task automatic trip(input int kind);
        int n0;
        n0 = irqCnt;
        syncIn <= 1'b1;
        tick(1);
        case (kind)
            0: pinOpen <= 1'b1;
            1: overCmd <= 3'h2;
            2: floatCmd <= 3'h4;
            default: axw(ADDR_SWTRIP, 32'h1);
        endcase
        #10;
        chk("tripOut", 6'h00, pwmOut);
        chk("tripSync", 1'b0, syncOut);
        tick(8);
        chk("tripIrq", n0 + 1, irqCnt);
        axr(ADDR_STATUS);
        chk("pinLvl", kind != 0, rd[STAT_PIN_BIT]);
        chk("tripStat", 1'b1, rd[STAT_TRIP_BIT]);
        pinOpen <= 1'b0;
        overCmd <= 3'h0;
        floatCmd <= 3'h0;
        syncIn <= 1'b0;
        tick(8);
        chk("holdOff", 6'h00, pwmOut);
        axr(ADDR_SWTRIP);
        chk("tripSrc", kind == 3, rd[0]);
        axr(ADDR_SWTRIP);
        chk("tripClr", 1'b0, rd[0]);
        start();
        chk("restart", expOut(tuOut, cur), pwmOut);
        sync(1'b1);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        tick(2);
        #5 arst_n = 1'b1;
        tick(1);
        axr(ADDR_STEER);
        chk("steerRst", STEER_RST, rd);
        axr(ADDR_CHOP);
        chk("chopRst", CHOP_RST, rd);
        axr(ADDR_STATUS);
        chk("pinIdle", 1'b1, rd[STAT_PIN_BIT]);
        axr(16'h0010);
        chk("unmapRd", RESP_SLVERR, rsp);
        axw(16'h0010, 32'h1ff);
        chk("unmapWr", RESP_SLVERR, rsp);
        axw(ADDR_CHOP, 32'h0);
        tuOut <= 6'h3f;
        tick(4);
        start();
        chk("runOut", 6'h3f, pwmOut);
        sync(1'b1);
        tdone("reset and start");
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            steer(i < 4 ? corner[i] : seed[8:0], seed[14:9], 1'b0);
        end
        tdone("steering");
        seed = lfsr(seed);
        tuOut <= seed[5:0];
        axw(ADDR_STEER, {23'h0, ~cur});
        half();
        chk("singleHalf", expOut(seed[5:0], cur), pwmOut);
        sync(1'b1);
        cur = ~cur;
        dblUpd <= 1'b1;
        steer(seed[8:0] ^ 9'h155, seed[14:9], 1'b1);
        dblUpd <= 1'b0;
        tdone("double update");
        steer(9'h000, 6'h3f, 1'b0);
        chop(10'h101, 32, 64);
        chop(10'h200, 64, 32);
        chop(10'h303, 32, 32);
        chop(10'h000, 64, 64);
        tdone("chopping");
        for (int k = 0; k < 4; k++) trip(k);
        tdone("shutdown");
        axw(ADDR_STEER, 32'h1ff);
        axw(ADDR_CHOP, 32'h3ff);
        #5 arst_n = 1'b0;
        tick(2);
        #5 arst_n = 1'b1;
        tick(1);
        axr(ADDR_STEER);
        chk("steerRst2", STEER_RST, rd);
        axr(ADDR_CHOP);
        chk("chopRst2", CHOP_RST, rd);
        chk("rstOut", 6'h00, pwmOut);
        tdone("mid-run reset");
        end_of_test();
    end

    initial begin
        tick(30000);
        n_errors++;
        end_of_test();
    end
endmodule // tb_pwm_output_steer_chop_trip

`default_nettype wire
